// ### src/mcs_regs.svh
// register indices, field positions, reset values and counts of the multichip sync block
// assumes an APB slave with 32-bit data; byte address of a register is four times its index
//
// Summary of operation
// - two sync modes exist, data-rate and FIFO-rate, each aligning a different clock.
// - data-rate mode aligns to the input word rate.
// - FIFO-rate mode aligns every eight input words, the FIFO depth.
// - data-rate mode uses no FIFO slack; keep-out recurs every word.
// - FIFO-rate mode spaces keep-out windows eight words apart, not one.
// - with the internal multiplier clocking, only data-rate mode is allowed.
// - with a directly supplied sample clock, both modes are allowed.
// - with the multiplier, the reference input also serves as sync event.
// - devices are synced when clock state and FIFO read point agree.
// - a fixed relation ties clock state, read data and a reference edge.
// - status bit 6 shows locked, bit 7 shows lock lost.
// - after lock, a two-word frame strobe resets the FIFO read point.
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

`define MCS_IDX_SYNC_CTRL 8'h10
`define MCS_IDX_CLK_CFG 8'h11
`define MCS_IDX_SYNC_STAT 8'h12
`define MCS_IDX_IRQ_STAT 8'h13
`define MCS_IDX_IRQ_MASK 8'h14

`define MCS_CTRL_EN_BIT 7
`define MCS_CTRL_DATA_BIT 6
`define MCS_STAT_LOST_BIT 7
`define MCS_STAT_LOCK_BIT 6
`define MCS_CFG_PLL_BIT 0
`define MCS_IRQ_LOCK_BIT 0
`define MCS_IRQ_LOST_BIT 1
`define MCS_IRQ_FRST_BIT 2

`define MCS_CTRL_RST 8'h00
`define MCS_CFG_RST 8'h00
`define MCS_MASK_RST 3'h0

`define MCS_FIFO_DEPTH 8
`define MCS_LOCK_MATCHES 3'h4
`define MCS_FRAME_WORDS 2'h2
`define MCS_RD_START 3'h4

`endif

// ### src/mcs_pkg.sv
// types shared by the multichip sync block
// assumes the register header is included where offsets are needed
`default_nettype none
package mcs_pkg;
  typedef enum logic [2:0] {
    MCS_OFF = 3'b001,
    MCS_ACQ = 3'b010,
    MCS_LOCK = 3'b100
  } mcs_state_t;
  typedef enum logic {
    MCS_FIFO_RATE = 1'b0,
    MCS_DATA_RATE = 1'b1
  } mcs_mode_t;
endpackage
`default_nettype wire

// ### src/mcs_pin_sync.sv
// two-stage synchroniser for a pin with a rising-edge detector behind it
// assumes the pin is asynchronous to mclk and slow against it
`timescale 1ns/1ps
`default_nettype none
module mcs_pin_sync (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic level,
  output logic rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // edge detection looks only at the second and third stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// ### src/mcs_sync_top.sv
// multichip sync logic: aligns clock-generation phase to the reference input in FIFO-rate mode, FIFO read point to the frame strobe
// assumes APB master on mclk; reference, word clock and frame pins are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_sync_top
  import mcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reference_sync_clock_in,
  input wire logic source_word_clock_in,
  input wire logic frame_in,
  output logic sync_locked,
  output logic sync_lost,
  output logic [2:0] gen_phase,
  output logic [2:0] fifo_rd_ptr,
  output logic fifo_reset_pulse,
  output logic irq
);
  function automatic logic reg_at(input logic [11:0] addr, input logic [7:0] idx);
    reg_at = (addr == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = reg_at(addr, `MCS_IDX_SYNC_CTRL) | reg_at(addr, `MCS_IDX_CLK_CFG) |
                  reg_at(addr, `MCS_IDX_SYNC_STAT) | reg_at(addr, `MCS_IDX_IRQ_STAT) |
                  reg_at(addr, `MCS_IDX_IRQ_MASK);
  endfunction

  logic ref_evt;
  logic word_evt;
  logic frame_lvl;
  logic [7:0] ctrl_reg;
  logic [7:0] cfg_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic [2:0] wcnt_reg;
  logic [1:0] gap_reg;
  logic [2:0] match_reg;
  logic lost_reg;
  logic [1:0] frame_words_reg;
  logic fifo_rst_reg;
  logic [2:0] rd_ptr_reg;
  mcs_state_t state_reg;
  mcs_state_t state_next;
  mcs_mode_t mode_eff;
  logic sync_en;
  logic use_pll;
  logic setup;
  logic wr_acc;
  logic mismatch;
  logic match;
  logic lock_evt;
  logic lost_evt;
  logic frst_evt;
  logic [2:0] irq_set;

  mcs_pin_sync u_ref_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(reference_sync_clock_in),
    .level(),
    .rise(ref_evt)
  );

  mcs_pin_sync u_word_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(source_word_clock_in),
    .level(),
    .rise(word_evt)
  );

  mcs_pin_sync u_frame_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(frame_in),
    .level(frame_lvl),
    .rise()
  );

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign prdata = prdata_reg;

  assign sync_en = ctrl_reg[`MCS_CTRL_EN_BIT];
  assign use_pll = cfg_reg[`MCS_CFG_PLL_BIT];

  // mode gating
  // the multiplier path forces data-rate alignment whatever software asked for
  assign mode_eff = use_pll ? MCS_DATA_RATE : mcs_mode_t'(ctrl_reg[`MCS_CTRL_DATA_BIT]);

  // phase check
  // data-rate expects exactly one word between reference edges, FIFO-rate expects phase zero
  assign mismatch = ref_evt & sync_en &
                    ((mode_eff == MCS_DATA_RATE) ? (gap_reg != 2'h1) : (wcnt_reg != 3'h0));
  assign match = ref_evt & sync_en & ~mismatch;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `MCS_CTRL_RST;
      cfg_reg <= `MCS_CFG_RST;
      irq_mask_reg <= `MCS_MASK_RST;
    end else if (wr_acc) begin
      if (reg_at(paddr, `MCS_IDX_SYNC_CTRL)) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (reg_at(paddr, `MCS_IDX_CLK_CFG)) begin
        cfg_reg <= pwdata[7:0];
      end
      if (reg_at(paddr, `MCS_IDX_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[2:0];
      end
    end
  end

  // read data is captured in the setup cycle so it stands from flip-flops in the access cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= 32'h0000_0000;
      if (reg_at(paddr, `MCS_IDX_SYNC_CTRL)) begin
        prdata_reg <= {24'h00_0000, ctrl_reg};
      end else if (reg_at(paddr, `MCS_IDX_CLK_CFG)) begin
        prdata_reg <= {24'h00_0000, cfg_reg};
      end else if (reg_at(paddr, `MCS_IDX_SYNC_STAT)) begin
        prdata_reg <= {24'h00_0000, lost_reg, (state_reg == MCS_LOCK), 3'h0, rd_ptr_reg};
      end else if (reg_at(paddr, `MCS_IDX_IRQ_STAT)) begin
        prdata_reg <= {29'h0000_0000, irq_stat_reg};
      end else if (reg_at(paddr, `MCS_IDX_IRQ_MASK)) begin
        prdata_reg <= {29'h0000_0000, irq_mask_reg};
      end
    end
  end

  // word gap count
  // counts word edges since the last reference edge; saturates so a stalled reference reads as a miss
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg <= 2'h0;
    end else if (ref_evt) begin
      gap_reg <= word_evt ? 2'h1 : 2'h0;
    end else if (word_evt && gap_reg != 2'h3) begin
      gap_reg <= gap_reg + 2'h1;
    end
  end

  // clock phase realign
  // in FIFO-rate mode a reference edge on a wrong phase restarts the eight-word cycle at zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wcnt_reg <= 3'h0;
    end else if (mismatch && mode_eff == MCS_FIFO_RATE) begin
      wcnt_reg <= word_evt ? 3'h1 : 3'h0;
    end else if (word_evt) begin
      wcnt_reg <= wcnt_reg + 3'h1;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MCS_OFF: begin
        if (sync_en) begin
          state_next = MCS_ACQ;
        end
      end
      MCS_ACQ: begin
        if (!sync_en) begin
          state_next = MCS_OFF;
        end else if (match && match_reg == `MCS_LOCK_MATCHES - 3'h1) begin
          state_next = MCS_LOCK;
        end
      end
      MCS_LOCK: begin
        if (!sync_en) begin
          state_next = MCS_OFF;
        end else if (mismatch) begin
          state_next = MCS_ACQ;
        end
      end
      default: begin
        state_next = MCS_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= MCS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      match_reg <= 3'h0;
    end else if (state_reg != MCS_ACQ || mismatch) begin
      match_reg <= 3'h0;
    end else if (match) begin
      match_reg <= match_reg + 3'h1;
    end
  end

  assign lock_evt = (state_reg == MCS_ACQ) & (state_next == MCS_LOCK);
  assign lost_evt = (state_reg == MCS_LOCK) & mismatch;

  // lost flag
  // sticky until sync control is rewritten; a loss in that same cycle still sets it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lost_reg <= 1'b0;
    end else if (lost_evt) begin
      lost_reg <= 1'b1;
    end else if (wr_acc && reg_at(paddr, `MCS_IDX_SYNC_CTRL)) begin
      lost_reg <= 1'b0;
    end
  end

  // frame word count
  // one FIFO reset per strobe; the strobe must go low before it can fire again
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frame_words_reg <= 2'h0;
    end else if (!frame_lvl) begin
      frame_words_reg <= 2'h0;
    end else if (word_evt && frame_words_reg != `MCS_FRAME_WORDS) begin
      frame_words_reg <= frame_words_reg + 2'h1;
    end
  end

  assign frst_evt = frame_lvl & word_evt & (frame_words_reg == `MCS_FRAME_WORDS - 2'h1) &
                    (state_reg == MCS_LOCK);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_rst_reg <= 1'b0;
    end else begin
      fifo_rst_reg <= frst_evt;
    end
  end

  // read point
  // read pointer sits half the depth behind writes after a reset, giving slack both ways
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_reg <= `MCS_RD_START;
    end else if (fifo_rst_reg) begin
      rd_ptr_reg <= `MCS_RD_START;
    end else if (word_evt) begin
      rd_ptr_reg <= rd_ptr_reg + 3'h1;
    end
  end

  assign irq_set = {fifo_rst_reg, lost_evt, lock_evt};

  // write-one-to-clear; a new event in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= 3'h0;
    end else if (wr_acc && reg_at(paddr, `MCS_IDX_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);
  assign sync_locked = (state_reg == MCS_LOCK);
  assign sync_lost = lost_reg;
  assign gen_phase = wcnt_reg;
  assign fifo_rd_ptr = rd_ptr_reg;
  assign fifo_reset_pulse = fifo_rst_reg;

  sequence lock_taken_s;
    state_reg == MCS_ACQ && match && match_reg == 3'h3;
  endsequence

  sequence lock_shown_s;
    ##1 sync_locked && irq_stat_reg[`MCS_IRQ_LOCK_BIT];
  endsequence

  pll_forces_data_a: assert property (@(posedge mclk) disable iff (!rst_b)
    use_pll |-> mode_eff == MCS_DATA_RATE)
    else $error("multiplier clocking left FIFO-rate mode active");

  direct_fifo_mode_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !use_pll && !ctrl_reg[`MCS_CTRL_DATA_BIT] |-> mode_eff == MCS_FIFO_RATE)
    else $error("direct clocking did not allow FIFO-rate mode");

  data_gap_check_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_evt && sync_en && mode_eff == MCS_DATA_RATE && sync_locked && gap_reg != 2'h1 |=>
    !sync_locked && sync_lost)
    else $error("data-rate gap error did not drop lock");

  fifo_realign_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_evt && sync_en && mode_eff == MCS_FIFO_RATE && wcnt_reg != 3'h0 |=>
    wcnt_reg == ($past(word_evt) ? 3'h1 : 3'h0))
    else $error("FIFO-rate phase not realigned");

  lock_after_matches_a: assert property (@(posedge mclk) disable iff (!rst_b)
    lock_taken_s |-> lock_shown_s)
    else $error("lock not reached after required matches");

  lost_on_mismatch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sync_locked && mismatch |=> sync_lost && !sync_locked)
    else $error("loss of lock not reported");

  disabled_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !sync_en |=> state_reg == MCS_OFF)
    else $error("sync logic active while disabled");

  fifo_reset_point_a: assert property (@(posedge mclk) disable iff (!rst_b)
    fifo_reset_pulse |-> $past(sync_locked) && $past(frame_words_reg) == 2'h1
    ##1 fifo_rd_ptr == `MCS_RD_START + {2'b00, $past(word_evt)})
    else $error("FIFO reset not tied to two-word strobe");

  irq_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
    irq == |(irq_stat_reg & irq_mask_reg))
    else $error("interrupt level disagrees with status and mask");

  // a clearing write in the event cycle must not swallow the event
  irq_set_wins_a: assert property (@(posedge mclk) disable iff (!rst_b)
    irq_set != 3'h0 |=> (irq_stat_reg & $past(irq_set)) == $past(irq_set))
    else $error("status event lost against a clearing write");

  fifo_reset_once_a: assert property (@(posedge mclk) disable iff (!rst_b)
    fifo_reset_pulse |=> !fifo_reset_pulse)
    else $error("FIFO reset pulse longer than one cycle");
endmodule
`default_nettype wire

// ### verification/mcs_src_model.sv
// behavioural data source: word clock, reference clock and frame strobe
// assumes the bench sets the controls; the model paces itself in ns
`timescale 1ns/1ps
`default_nettype none
module mcs_src_model (
  input wire logic run,
  input wire logic fifo_rate,
  input wire logic frame_req,
  input wire logic skip_ref,
  output logic ref_out,
  output logic word_out,
  output logic frame_out
);
  int n;
  int fl;
  initial begin
    ref_out = 1'b0;
    word_out = 1'b0;
    frame_out = 1'b0;
    n = 0;
    fl = 0;
    // odd offset keeps link edges off the mclk edges
    #37;
    forever begin
      if (!run) begin
        // clocks stand still while the source is idle
        word_out = 1'b0;
        ref_out = 1'b0;
        #100;
      end else begin
        word_out = 1'b1;
        ref_out = 1'b0;
        n = n + 1;
        if (frame_out) fl = fl + 1;
        #400;
        word_out = 1'b0;
        // reference at word rate, or every eighth word when fifo_rate is set
        // skipping an edge is how the bench provokes a phase mismatch
        ref_out = !skip_ref && (n % (fifo_rate ? 8 : 1) == 0);
        if (frame_out && fl >= 2) begin
          frame_out = 1'b0;
        end else if (frame_req && !frame_out) begin
          frame_out = 1'b1;
          fl = 0;
        end
        #400;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/mcs_sync_top_tb.sv
// self-checking bench of the multichip sync block
// assumes the source model drives the link pins; registers go over APB
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_sync_top_tb;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, refc, word, frame;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic sync_locked, sync_lost, fifo_reset_pulse, irq, rd_err, run, fifo_rate, frame_req, skip_ref;
  logic [2:0] gen_phase, fifo_rd_ptr;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam logic [11:0] A_CTRL = {2'b00, `MCS_IDX_SYNC_CTRL, 2'b00};
  localparam logic [11:0] A_CFG = {2'b00, `MCS_IDX_CLK_CFG, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, `MCS_IDX_SYNC_STAT, 2'b00};
  localparam logic [11:0] A_IST = {2'b00, `MCS_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MSK = {2'b00, `MCS_IDX_IRQ_MASK, 2'b00};
  mcs_sync_top mcs_sync_top_i (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_sync_clock_in(refc), .source_word_clock_in(word), .frame_in(frame), .sync_locked(sync_locked),
    .sync_lost(sync_lost), .gen_phase(gen_phase), .fifo_rd_ptr(fifo_rd_ptr),
    .fifo_reset_pulse(fifo_reset_pulse), .irq(irq));
  mcs_src_model mcs_src_model_i (.run(run), .fifo_rate(fifo_rate), .frame_req(frame_req), .skip_ref(skip_ref),
    .ref_out(refc), .word_out(word), .frame_out(frame));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      n_mismatch++;
      conclude();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read data and error are taken at the edge where pready is seen high
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask
  task wait_lock(input logic want);
    for (int i = 0; i < 3000 && sync_locked !== want; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("sync_locked", {31'h0, want}, {31'h0, sync_locked});
  endtask
  task t_reset;
    #1;
    chk("gen_phase", 32'h0, {29'h0, gen_phase});
    chk("fifo_rd_ptr", 32'h4, {29'h0, fifo_rd_ptr});
    chk("irq", 32'h0, {31'h0, irq});
    chk("pready", 32'h1, {31'h0, pready});
    chk("sync_locked reset", 32'h0, {31'h0, sync_locked});
    chk("sync_lost reset", 32'h0, {31'h0, sync_lost});
    chk("fifo reset idle", 32'h0, {31'h0, fifo_reset_pulse});
    rd(A_STAT);
    chk("status", 32'h4, rd_data);
    rd(A_CTRL);
    chk("ctrl", 32'h0, rd_data);
    rd(A_CFG);
    chk("cfg", 32'h0, rd_data);
    rd(A_MSK);
    chk("mask", 32'h0, rd_data);
    rd(12'h000);
    chk("unmapped err", 32'h1, {31'h0, rd_err});
    chk("unmapped data", 32'h0, rd_data);
  endtask
  task t_data_lock;
    wr(A_MSK, 32'h7);
    fifo_rate <= 1'b0;
    run <= 1'b1;
    wr(A_CTRL, 32'hC0);
    wait_lock(1'b1);
    rd(A_STAT);
    chk("status lock bits", 32'h1, {30'h0, rd_data[7:6]});
    rd(A_IST);
    chk("irq lock bit", 32'h1, {31'h0, rd_data[0]});
    wr(A_IST, 32'h1);
    rd(A_IST);
    chk("irq lock cleared", 32'h0, {31'h0, rd_data[0]});
    chk("irq low", 32'h0, {31'h0, irq});
    repeat (200) @(posedge mclk);
    #1;
    chk("lock held", 32'h1, {31'h0, sync_locked});
  endtask
  task t_frame;
    frame_req <= 1'b1;
    for (int i = 0; i < 300 && fifo_reset_pulse !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("fifo reset", 32'h1, {31'h0, fifo_reset_pulse});
    @(posedge mclk);
    frame_req <= 1'b0;
    #1;
    chk("fifo reset width", 32'h0, {31'h0, fifo_reset_pulse});
    chk("rd ptr start", 32'h2, {30'h0, fifo_rd_ptr[2:1]});
    rd(A_IST);
    chk("irq frame bit", 32'h1, {31'h0, rd_data[2]});
    wr(A_IST, 32'h4);
  endtask
  task t_loss;
    // mismatches are judged only at reference edges, so drop two edges and then resume
    skip_ref <= 1'b1;
    repeat (12) @(posedge mclk);
    skip_ref <= 1'b0;
    wait_lock(1'b0);
    chk("sync_lost", 32'h1, {31'h0, sync_lost});
    rd(A_STAT);
    chk("status lost", 32'h1, {31'h0, rd_data[7]});
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(A_MSK, 32'h0);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_IST, 32'h2);
    wr(A_CTRL, 32'hC0);
    rd(A_STAT);
    chk("lost cleared", 32'h0, {31'h0, rd_data[7]});
    wait_lock(1'b1);
  endtask
  task t_fifo;
    wr(A_CTRL, 32'h0);
    wait_lock(1'b0);
    fifo_rate <= 1'b1;
    wr(A_CFG, 32'h0);
    wr(A_CTRL, 32'h80);
    wait_lock(1'b1);
    for (int i = 0; i < 300 && refc !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("phase at reference", 32'h0, {29'h0, gen_phase});
    repeat (200) @(posedge mclk);
    #1;
    chk("fifo lock held", 32'h1, {31'h0, sync_locked});
  endtask
  task t_pll;
    wr(A_CTRL, 32'h0);
    wait_lock(1'b0);
    // word-rate reference only locks if the mode is forced to data-rate
    fifo_rate <= 1'b0;
    wr(A_CFG, 32'h1);
    wr(A_CTRL, 32'h80);
    wait_lock(1'b1);
    rd(A_CFG);
    chk("cfg", 32'h1, rd_data);
  endtask
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run = 1'b0;
    fifo_rate = 1'b0;
    frame_req = 1'b0;
    skip_ref = 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_data_lock();
    t_frame();
    t_loss();
    t_fifo();
    t_pll();
    conclude();
  end
endmodule
`default_nettype wire
